// *** rtl/horiz_blanking_repeat_pattern_gen.sv ***
// Horizontal blanking pattern generator with toggle, repeat and repeat-area modes.
`timescale 1ns/1ns
`default_nettype none
`include "horiz_blanking_regs.svh"

// Overview of operation
// RL1: Each of six areas holds three 4-bit phase-one pulse counts, 0 to 15.
// RL2: Phase-two counts per area: start A bits 3:0, B bits 7:4, C bits 11:8.
// RL3: Even lines use area counts directly; odd lines only via area selectors.
// RL4: Three shared 13-bit start positions A, B, C originate pulse groups.
// RL5: Host sets unused start positions to 8191 so they never fire.
// RL6: Six 3-bit odd-line selectors each name an even area 0 to 5.
// RL7: Mode 1 repeats blanking pulses from start, end, length, count and toggles.
// RL8: Modes 0 and 1 use separate even and odd toggle sets by line parity.
// RL9: Host loads equal even and odd toggles when alternation is unwanted.
// RL10: Line alternation here is independent of vertical pattern alternation.
// RL11: Mode 0 toggles, 1 repeat plus toggles, 2 areas, 3 test and unused.
// RL12: Start, end, length and repeat count are 13-bit values 0 to 8191.
// RL13: Odd, even and last-stage clocks rest at separate mask levels in blanking.
// RL14: A zero pulse count suppresses that pulse group in its area.
// RL15: Line parity counts from each field start; the first line is even.
module horiz_blanking_repeat_pattern_gen #(
  parameter int unsigned NUM_AREAS = 6,
  parameter int unsigned POS_W     = 13
) (
  input  wire logic              i_mclk,
  input  wire logic              i_reset_n,
  input  wire logic              i_ce,
  input  wire logic              i_line_start,
  input  wire logic              i_field_start,
  input  wire horiz_blanking_pkg::ser_pins_s i_ser,
  output var  horiz_blanking_pkg::hclk_s   o_hclk,
  output logic                   o_horiz_blanking,
  output logic                   o_line_odd
);
  import horiz_blanking_pkg::*;

  // ==========================================================================
  // Elaboration checks
  // The area counters and register layout are built for six 13-bit areas.
  if (NUM_AREAS != 6 || POS_W != 13) begin : g_bad_param
    $error("Only six areas with 13-bit positions are supported.");
  end

  // ==========================================================================
  // Helper functions
  // Reset image of the whole state; unused starts park at the last pixel.
  function automatic state_s rst_state();
    state_s r;
    r = '0;
    r.cfg.mode      = blank_mode_e'(`RST_MODE);
    r.cfg.start     = `RST_POS;
    r.cfg.stop      = `RST_POS;
    r.cfg.len       = `RST_LEN;
    r.cfg.tog_e     = {6{`RST_POS}};
    r.cfg.tog_o     = {6{`RST_POS}};
    r.cfg.start_abc = {3{`RST_POS}};
    r.s1.sl         = 1'b1;
    r.s2.sl         = 1'b1;
    r.sl_d          = 1'b1;
    r.area          = `AREA_DONE;
    return r;
  endfunction

  // Decodes an address inside a block of six consecutive registers.
  function automatic logic [3:0] blk_hit(logic [7:0] a, logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    blk_hit = {(a >= base) && (d < 8'h06), d[2:0]};
  endfunction

  // Half-open pixel window test.
  function automatic logic in_win(pos_t p, pos_t a, pos_t b);
    in_win = (p >= a) && (p < b);
  endfunction

  // ==========================================================================
  // State
  state_s s_ff;
  state_s nxt_s;

  // Next-state logic for configuration, line timing and pulse generation.
  always_comb begin
    logic       sck_rise;
    logic [7:0] wa;
    logic [15:0] wd;
    logic [3:0] hit;
    logic [12:0] tg [6];
    logic       blank;
    logic       pass1;
    logic       pass2;
    logic [2:0] eff;
    logic       eff_ok;
    logic [11:0] c1;
    logic [11:0] c2;
    logic       win;
    sck_rise = 1'b0;
    wa       = 8'h00;
    wd       = 16'h0000;
    hit      = 4'h0;
    blank    = 1'b0;
    pass1    = 1'b0;
    pass2    = 1'b0;
    eff      = 3'h0;
    eff_ok   = 1'b0;
    c1       = 12'h000;
    c2       = 12'h000;
    win      = 1'b0;
    for (int i = 0; i < 6; i++) begin
      tg[i] = 13'h0000;
    end
    nxt_s = s_ff;

    // Serial pins pass two flops; only the second stage is examined.
    nxt_s.s1    = i_ser;
    nxt_s.s2    = s_ff.s1;
    nxt_s.sck_d = s_ff.s2.sck;
    nxt_s.sl_d  = s_ff.s2.sl;
    sck_rise    = s_ff.s2.sck & ~s_ff.sck_d;
    wa          = s_ff.sh[7:0];
    wd          = s_ff.sh[23:8];

    // Shift LSB first while load is low; commit a full word on load rising.
    if (!s_ff.s2.sl) begin
      if (sck_rise && s_ff.bits != `SER_BITS) begin
        nxt_s.sh   = {s_ff.s2.sdata, s_ff.sh[23:1]};
        nxt_s.bits = s_ff.bits + 5'h01;
      end
    end else begin
      nxt_s.bits = 5'h00;
      if (!s_ff.sl_d && s_ff.bits == `SER_BITS) begin
        unique case (wa)
          `ADR_MODE: begin
            nxt_s.cfg.mode    = blank_mode_e'(wd[`FLD_MODE_LSB +: 2]); // RL11
            nxt_s.cfg.mask_h1 = wd[`FLD_MASK_H1]; // RL13
            nxt_s.cfg.mask_h2 = wd[`FLD_MASK_H2];
            nxt_s.cfg.mask_hl = wd[`FLD_MASK_HL];
          end
          `ADR_START: nxt_s.cfg.start = wd[12:0]; // RL12
          `ADR_END:   nxt_s.cfg.stop  = wd[12:0];
          `ADR_LEN:   nxt_s.cfg.len   = wd[12:0];
          `ADR_REP:   nxt_s.cfg.rep   = wd[12:0];
          default: begin
            hit = blk_hit(wa, `ADR_TOG_E);
            if (hit[3]) nxt_s.cfg.tog_e[hit[2:0]] = wd[12:0]; // RL8
            hit = blk_hit(wa, `ADR_TOG_O);
            if (hit[3]) nxt_s.cfg.tog_o[hit[2:0]] = wd[12:0];
            hit = blk_hit(wa, `ADR_H1CNT);
            if (hit[3]) nxt_s.cfg.h1cnt[hit[2:0]] = wd[11:0]; // RL1
            hit = blk_hit(wa, `ADR_H2CNT);
            if (hit[3]) nxt_s.cfg.h2cnt[hit[2:0]] = wd[11:0]; // RL2
            hit = blk_hit(wa, `ADR_START_ABC);
            if (hit[3] && hit[2:0] < 3'h3) begin
              nxt_s.cfg.start_abc[hit[1:0]] = wd[12:0]; // RL4
            end
            hit = blk_hit(wa, `ADR_ALT_SEL);
            if (hit[3]) nxt_s.cfg.alt_sel[hit[2:0]] = wd[2:0]; // RL6
          end
        endcase
      end
    end

    // Pixel counter and line parity; a field start forces an even line.
    // Without line starts the counter simply wraps after the last pixel.
    nxt_s.pix = s_ff.pix + 13'h0001;
    if (i_field_start) begin
      nxt_s.odd = 1'b0; // RL15
      nxt_s.pix = 13'h0000;
    end else if (i_line_start) begin
      nxt_s.odd = ~s_ff.odd; // RL10
      nxt_s.pix = 13'h0000;
    end

    // Toggle windows from the set matching the current line parity.
    for (int i = 0; i < 6; i++) begin
      tg[i] = s_ff.odd ? s_ff.cfg.tog_o[i] : s_ff.cfg.tog_e[i]; // RL8
    end
    blank = in_win(s_ff.pix, tg[0], tg[1]) || in_win(s_ff.pix, tg[2], tg[3])
         || in_win(s_ff.pix, tg[4], tg[5]);
    win   = in_win(s_ff.pix, s_ff.cfg.start, s_ff.cfg.stop); // RL12

    // Repeat mode: blank the window, pass one clock each repetition length, up to the repeat count.
    if (s_ff.pix == s_ff.cfg.start) begin
      nxt_s.ph    = 13'h0000;
      nxt_s.rep_n = 13'h0000;
    end else if (win) begin
      nxt_s.ph = s_ff.ph + 13'h0001;
      if (s_ff.ph + 13'h0001 >= s_ff.cfg.len) begin
        nxt_s.ph = 13'h0000;
        if (s_ff.rep_n < s_ff.cfg.rep) begin
          nxt_s.rep_n = s_ff.rep_n + 13'h0001;
        end
      end
    end

    // Area mode: six areas of one length each, groups at shared starts.
    // Odd lines borrow an even area through its selector; above 5 gives none.
    eff    = s_ff.odd ? s_ff.cfg.alt_sel[s_ff.area] : s_ff.area; // RL3
    eff_ok = (s_ff.area < `AREA_DONE) && (eff < `AREA_DONE);
    c1     = eff_ok ? s_ff.cfg.h1cnt[eff] : 12'h000;
    c2     = eff_ok ? s_ff.cfg.h2cnt[eff] : 12'h000;
    if (s_ff.pix == s_ff.cfg.start) begin
      nxt_s.area = 3'h0;
      nxt_s.apos = 13'h0000;
      nxt_s.r1   = 4'h0;
      nxt_s.r2   = 4'h0;
    end else if (win && s_ff.area < `AREA_DONE) begin
      nxt_s.apos = s_ff.apos + 13'h0001;
      if (s_ff.apos + 13'h0001 >= s_ff.cfg.len) begin
        nxt_s.apos = 13'h0000;
        nxt_s.area = s_ff.area + 3'h1;
      end
    end

    // Pulse counters; unused starts at 8191 never match an area position.
    // Loads wait until the window's first pixel has cleared the area position,
    // so an area and position left from the previous line never fire a group.
    if (s_ff.r1 != 4'h0) begin
      nxt_s.p1 = ~s_ff.p1;
      if (s_ff.p1) nxt_s.r1 = s_ff.r1 - 4'h1;
    end
    if (s_ff.r2 != 4'h0) begin
      nxt_s.p2 = ~s_ff.p2;
      if (s_ff.p2) nxt_s.r2 = s_ff.r2 - 4'h1;
    end
    for (int k = 0; k < 3; k++) begin
      if (win && (s_ff.pix != s_ff.cfg.start) && s_ff.area < `AREA_DONE
          && s_ff.apos == s_ff.cfg.start_abc[k]) begin // RL5
        nxt_s.r1 = c1[k*4 +: 4]; // RL1
        nxt_s.r2 = c2[k*4 +: 4]; // RL2
        nxt_s.p1 = 1'b0;
        nxt_s.p2 = 1'b0;
      end
    end

    // Mode selection for the blanking level and pulse pass-through.
    unique case (s_ff.cfg.mode)
      MODE_TOGGLE: begin
        nxt_s.horiz_blanking = blank; // RL11
        pass1      = 1'b0;
        pass2      = 1'b0;
      end
      MODE_MIX: begin
        nxt_s.horiz_blanking = blank || win; // RL7
        // The window's first pixel only restarts the phase; the phase left
        // over from the previous line must not make a pass cycle there.
        pass1 = win && (s_ff.pix != s_ff.cfg.start) && (s_ff.rep_n < s_ff.cfg.rep)
             && (s_ff.ph + 13'h0001 >= s_ff.cfg.len);
        pass2 = pass1;
      end
      MODE_AREA: begin
        nxt_s.horiz_blanking = win;
        pass1      = s_ff.r1 != 4'h0; // RL14
        pass2      = s_ff.r2 != 4'h0;
      end
      MODE_TEST: begin
        nxt_s.horiz_blanking = 1'b0; // RL11
        pass1      = 1'b0;
        pass2      = 1'b0;
      end
    endcase

    // Free-running clock phase outside blanking; mask levels inside, apart from mode 1 and 2 pass cycles.
    nxt_s.run = ~s_ff.run;
    if (!nxt_s.horiz_blanking) begin
      nxt_s.hclk.h1 = s_ff.run;
      nxt_s.hclk.h2 = ~s_ff.run;
      nxt_s.hclk.hl = s_ff.run;
    end else begin
      nxt_s.hclk.h1 = s_ff.cfg.mask_h1; // RL13
      nxt_s.hclk.h2 = s_ff.cfg.mask_h2;
      nxt_s.hclk.hl = s_ff.cfg.mask_hl;
      if (s_ff.cfg.mode == MODE_AREA) begin
        if (pass1) nxt_s.hclk.h1 = s_ff.p1 ^ ~s_ff.cfg.mask_h1;
        if (pass1) nxt_s.hclk.hl = s_ff.p1 ^ ~s_ff.cfg.mask_hl;
        if (pass2) nxt_s.hclk.h2 = s_ff.p2 ^ ~s_ff.cfg.mask_h2;
      end else begin
        if (pass1) nxt_s.hclk.h1 = ~s_ff.cfg.mask_h1;
        if (pass1) nxt_s.hclk.hl = ~s_ff.cfg.mask_hl;
        if (pass2) nxt_s.hclk.h2 = ~s_ff.cfg.mask_h2;
      end
    end
  end

  // State register; clock enable low freezes everything.
  // Reset does not wait for the enable, so a frozen block still clears.
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      s_ff <= rst_state();
    end else if (i_ce) begin
      s_ff <= nxt_s;
    end
  end

  // Registered outputs.
  assign o_hclk     = s_ff.hclk;
  assign o_horiz_blanking     = s_ff.horiz_blanking;
  assign o_line_odd = s_ff.odd;
endmodule
`default_nettype wire

// *** rtl/horiz_blanking_regs.svh ***
// Register offsets, field positions, reset values and counts of the blanking generator.
`ifndef HORIZ_BLANKING_REGS_SVH
`define HORIZ_BLANKING_REGS_SVH
`define ADR_MODE      8'h00
`define ADR_START     8'h01
`define ADR_END       8'h02
`define ADR_LEN       8'h03
`define ADR_REP       8'h04
`define ADR_TOG_E     8'h08
`define ADR_TOG_O     8'h10
`define ADR_H1CNT     8'h18
`define ADR_H2CNT     8'h20
`define ADR_START_ABC 8'h28
`define ADR_ALT_SEL   8'h30
`define FLD_MODE_LSB  0
`define FLD_MASK_H1   2
`define FLD_MASK_H2   3
`define FLD_MASK_HL   4
`define RST_POS       13'h1FFF
`define RST_LEN       13'h0010
`define RST_MODE      2'h0
`define SER_BITS      5'h18
`define AREA_DONE     3'h6
`endif

// *** rtl/horiz_blanking_pkg.sv ***
// Types shared by the horizontal blanking pattern generator.
`default_nettype none
package horiz_blanking_pkg;
  // Blanking mode codes.
  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'b00,
    MODE_MIX    = 2'b01,
    MODE_AREA   = 2'b10,
    MODE_TEST   = 2'b11
  } blank_mode_e;
  typedef logic [12:0] pos_t;
  // Three-wire configuration pins.
  typedef struct packed {
    logic sl;
    logic sck;
    logic sdata;
  } ser_pins_s;
  // Horizontal clock outputs.
  typedef struct packed {
    logic h1;
    logic h2;
    logic hl;
  } hclk_s;
  // Programmable settings.
  typedef struct packed {
    blank_mode_e        mode;
    logic               mask_h1;
    logic               mask_h2;
    logic               mask_hl;
    pos_t               start;
    pos_t               stop;
    pos_t               len;
    pos_t               rep;
    logic [5:0][12:0]   tog_e;
    logic [5:0][12:0]   tog_o;
    logic [5:0][11:0]   h1cnt;
    logic [5:0][11:0]   h2cnt;
    logic [2:0][12:0]   start_abc;
    logic [5:0][2:0]    alt_sel;
  } cfg_s;
  // Whole state of the generator.
  typedef struct packed {
    cfg_s       cfg;
    ser_pins_s  s1;
    ser_pins_s  s2;
    logic       sck_d;
    logic       sl_d;
    logic [23:0] sh;
    logic [4:0] bits;
    pos_t       pix;
    logic       odd;
    pos_t       ph;
    pos_t       rep_n;
    logic [2:0] area;
    pos_t       apos;
    logic [3:0] r1;
    logic [3:0] r2;
    logic       p1;
    logic       p2;
    logic       run;
    hclk_s      hclk;
    logic       horiz_blanking;
  } state_s;
endpackage
`default_nettype wire

// *** tb/horiz_blanking_monitor.sv ***
// Port checker of the horizontal blanking generator, with its bind.
`timescale 1ns/1ns
`default_nettype none
module horiz_blanking_monitor (
  input wire logic            i_mclk,
  input wire logic            i_reset_n,
  input wire logic            i_ce,
  input wire logic            i_line_start,
  input wire logic            i_field_start,
  input wire horiz_blanking_pkg::hclk_s o_hclk,
  input wire logic            o_horiz_blanking,
  input wire logic            o_line_odd
);
  import horiz_blanking_pkg::*;
  // ==========================================
  // Checks on the pixel clock, idle in reset except reset_zero_a, which checks the reset values.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  reset_zero_a: assert property (disable iff (1'h0)
    !i_reset_n |=> !o_horiz_blanking && o_hclk == 3'h0 && !o_line_odd)
    else $error("outputs not cleared by reset");
  idle_inverse_a: assert property ($past(i_reset_n) && !o_horiz_blanking |->
    o_hclk.h2 == !o_hclk.h1) else $error("h2 not inverse of h1");
  idle_last_a: assert property ($past(i_reset_n) && !o_horiz_blanking |->
    o_hclk.hl == o_hclk.h1) else $error("hl differs from h1");
  idle_toggle_a: assert property ($past(i_reset_n, 2) && $past(i_ce) &&
    !o_horiz_blanking && !$past(o_horiz_blanking) |-> o_hclk.h1 != $past(o_hclk.h1))
    else $error("h1 stopped outside blanking");
  freeze_hold_a: assert property ($past(i_reset_n) && !$past(i_ce) |->
    $stable(o_hclk) && $stable(o_horiz_blanking) && $stable(o_line_odd))
    else $error("outputs moved with enable low");
  field_even_a: assert property (i_ce && i_field_start |-> ##[1:2] !o_line_odd)
    else $error("field start did not give even line");
  line_flip_a: assert property (i_ce && i_line_start && !i_field_start |=>
    ##[0:1] $changed(o_line_odd)) else $error("parity did not flip");
  parity_hold_a: assert property ($past(i_reset_n) && !$past(i_line_start) &&
    !$past(i_line_start, 2) |-> $stable(o_line_odd)) else $error("parity moved");
  // Main scenarios seen.
  cover property ($rose(o_horiz_blanking));
  cover property ($rose(o_line_odd));
  cover property (!i_ce);
endmodule
bind horiz_blanking_repeat_pattern_gen horiz_blanking_monitor i_mon (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_ce(i_ce), .i_line_start(i_line_start), .i_field_start(i_field_start),
  .o_hclk(o_hclk), .o_horiz_blanking(o_horiz_blanking), .o_line_odd(o_line_odd));
`default_nettype wire

// *** tb/ccd_hreg_model.sv ***
// Horizontal CCD register model that tallies blanking and clock pulses per line.
`timescale 1ns/1ns
`default_nettype none
module ccd_hreg_model (
  input wire logic             i_mclk,
  input wire logic             i_line_start,
  input wire logic             i_horiz_blanking,
  input wire horiz_blanking_pkg::hclk_s  i_hclk,
  input wire horiz_blanking_pkg::hclk_s  i_mask,
  output logic [15:0]          o_blank,
  output logic [15:0]          o_h1_act,
  output logic [15:0]          o_h2_act,
  output var horiz_blanking_pkg::hclk_s  o_seen
);
  import horiz_blanking_pkg::*;
  // Counts blanked cycles and cycles where a clock leaves its rest level.
  always_ff @(posedge i_mclk) begin
    if (i_line_start) begin
      o_blank <= 16'h0000;
      o_h1_act <= 16'h0000;
      o_h2_act <= 16'h0000;
    end else if (i_horiz_blanking) begin
      o_blank <= o_blank + 16'h0001;
      o_h1_act <= o_h1_act + 16'(i_hclk.h1 != i_mask.h1);
      o_h2_act <= o_h2_act + 16'(i_hclk.h2 != i_mask.h2);
      o_seen <= i_hclk;
    end
  end
endmodule
`default_nettype wire

// *** tb/horiz_blanking_repeat_pattern_gen_tb.sv ***
// Self-checking bench of the horizontal blanking generator.
`timescale 1ns/1ns
`default_nettype none
`include "horiz_blanking_regs.svh"
module horiz_blanking_repeat_pattern_gen_tb;
  import horiz_blanking_pkg::*;
  localparam int LINE = 200;
  logic        mclk = 1'h0;
  logic        reset_n = 1'h0;
  logic        ce = 1'h1;
  logic        ls = 1'h0;
  logic        fst = 1'h0;
  ser_pins_s   ser = 3'h4;
  hclk_s       hclk;
  logic        horiz_blanking;
  logic        odd;
  logic [15:0] blank, h1a, h2a;
  hclk_s       seen;
  int          checked = 0;
  int          miscompares = 0;
  // ==========================================
  // Device, far-side model and clock.
  horiz_blanking_repeat_pattern_gen i_dut (.i_mclk(mclk), .i_reset_n(reset_n), .i_ce(ce),
    .i_line_start(ls), .i_field_start(fst), .i_ser(ser), .o_hclk(hclk),
    .o_horiz_blanking(horiz_blanking), .o_line_odd(odd));
  ccd_hreg_model i_ccd (.i_mclk(mclk), .i_line_start(ls), .i_horiz_blanking(horiz_blanking), .i_hclk(hclk),
    .i_mask(3'h5), .o_blank(blank), .o_h1_act(h1a), .o_h2_act(h2a), .o_seen(seen));
  always #5 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // Serial write: address then data, LSB first, sck phases of 3 cycles.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [23:0] w;
    w = {d, a};
    ser.sl <= 1'h0;
    tick(3);
    for (int i = 0; i < 24; i++) begin
      ser.sdata <= w[i];
      tick(3);
      ser.sck <= 1'h1;
      tick(3);
      ser.sck <= 1'h0;
    end
    tick(3);
    ser.sl <= 1'h1;
    ser.sdata <= ~w[23];
    tick(6);
  endtask
  task automatic line(input logic fs);
    ls <= 1'h1;
    fst <= fs;
    tick(1);
    ls <= 1'h0;
    fst <= 1'h0;
    tick(LINE - 1);
  endtask
  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset levels, default mode, then a short enable freeze.
  task automatic t_reset();
    chk({11'h000, horiz_blanking, odd, hclk}, 16'h0000, "reset outputs");
    reset_n <= 1'h1;
    line(1'h1);
    chk(blank, 16'h0000, "default blank");
    chk(16'(odd), 16'h0000, "first line parity");
    ce <= 1'h0;
    tick(4);
    ce <= 1'h1;
    tick(1);
  endtask
  // Mode 0 with different even and odd toggles and mask levels.
  task automatic t_alt();
    wr(`ADR_MODE, 16'h0014);
    wr(`ADR_TOG_E, 16'h000A);
    wr(`ADR_TOG_E + 8'h01, 16'h0014);
    wr(`ADR_TOG_O, 16'h001E);
    wr(`ADR_TOG_O + 8'h01, 16'h002D);
    line(1'h1);
    chk(blank, 16'h000A, "even blank");
    chk(16'(seen), 16'h0005, "mask levels");
    line(1'h0);
    chk(blank, 16'h000F, "odd blank");
    chk(16'(odd), 16'h0001, "second line parity");
    line(1'h0);
    chk(blank, 16'h000A, "third line blank");
  endtask
  // Mode 1 window [100,140), length 10, repeat 0 then 2.
  task automatic t_mix();
    wr(`ADR_START, 16'h0064);
    wr(`ADR_END, 16'h008C);
    wr(`ADR_LEN, 16'h000A);
    wr(`ADR_MODE, 16'h0015);
    line(1'h1);
    chk(blank - h1a, 16'h0032, "mix held, no repeat");
    wr(`ADR_REP, 16'h0002);
    wr(`ADR_TOG_O, 16'h000A);
    wr(`ADR_TOG_O + 8'h01, 16'h0014);
    line(1'h0);
    chk(blank - h1a, 16'h0030, "mix held, two repeats");
    chk(h1a, 16'h0002, "mix pass cycles");
    chk(blank, 16'h0032, "odd line, equal toggles");
  endtask
  // Mode 2 areas of 20 from 100, starts A=2, B=8, C unused.
  task automatic t_area();
    wr(`ADR_LEN, 16'h0014);
    wr(`ADR_END, 16'h00A0);
    wr(`ADR_START_ABC, 16'h0002);
    wr(`ADR_START_ABC + 8'h01, 16'h0008);
    wr(`ADR_START_ABC + 8'h02, 16'h1FFF);
    wr(`ADR_H1CNT, 16'h0003);
    wr(`ADR_H2CNT, 16'h0021);
    wr(`ADR_H1CNT + 8'h01, 16'h0050);
    wr(`ADR_H2CNT + 8'h01, 16'h0000);
    wr(`ADR_ALT_SEL, 16'h0001);
    for (int k = 1; k < 6; k++) wr(`ADR_ALT_SEL + 8'(k), 16'h0006);
    wr(`ADR_MODE, 16'h0016);
    line(1'h1);
    chk(h1a, 16'h0008, "even phase-one pulses");
    chk(h2a, 16'h0003, "even phase-two pulses");
    line(1'h0);
    chk(h1a, 16'h0005, "odd phase-one pulses");
    chk(h2a, 16'h0000, "odd phase-two pulses");
  endtask
  // Unmapped write is ignored; mode 3 gives no blanking.
  task automatic t_test();
    wr(`ADR_MODE, 16'h0017);
    wr(8'h3F, 16'h0016);
    line(1'h1);
    chk(blank, 16'h0000, "mode 3 blank");
  endtask
  initial begin
    tick(16);
    t_reset();
    t_alt();
    t_mix();
    t_area();
    t_test();
    results();
  end
  // Cuts a hung run short.
  initial begin
    tick(30000);
    miscompares++;
    $display("BAD %0t run did not finish", $time);
    results();
  end
endmodule
`default_nettype wire
